// ===== tco_checksum_offload.sv
// Checksum offload and receive formatting between a MAC byte datapath and buffer DMA.
// Assumes one clock, store-and-forward frames, untagged IPv4 parsing, same-clock neighbours.
// How it works
// - Byte count is word/code length minus three.
// - Last-word code: 00b one byte, 11b four.
// - Info record follows data, 64-bit aligned.
// - Transmit header padding is never sent.
// - Receive fields stored in order, FCS last.
// - Switch tag replaces destination with timestamp fields.
// - Matched index n means address pair n+1.
// - Address filter on makes index invalid.
// - Transmit offload inserts IPv4, TCP, UDP sums.
// - Per-frame bypass skips transmit sums.
// - Transmit offload off: no sums, no padding.
// - No transport sum on fragmented transmit packets.
// - Zero transmit UDP sum becomes all ones.
// - Receive offload checks sums, flags mismatches.
// - Receive offload inserts two header pad bytes.
// - Receive transport sum overwrites stored FCS.
// - Header, extension or unlisted errors skip transport sum.
// - Fragment, ESP, AH extensions skip transport sum.
// - Suppress bit: pad only, no sums, FCS kept.
// - Receive offload off: no pad, no sums; only the switch tag can change the frame.
// - Zero received UDP sum is never flagged.
`timescale 1ns/1ns
`default_nettype none

// Parses one frame as its bytes arrive and accumulates the IPv4 and transport sums.
module tco_sum_unit
	import tco_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clr,
	input wire logic en,
	input wire logic [TCO_IW-1:0] idx,
	input wire logic [TCO_IW-1:0] base,
	input wire logic [7:0] data,
	output logic is_v4,
	output logic is_tcp,
	output logic is_udp,
	output logic is_frag,
	output logic [15:0] ip_calc,
	output logic [15:0] tp_calc,
	output logic [15:0] ip_field,
	output logic [15:0] tp_field,
	output logic [TCO_IW-1:0] ip_pos,
	output logic [TCO_IW-1:0] tp_pos
);
	logic et_hi_ff; // First type byte matched IPv4.
	logic et_ok_ff; // Whole type field matched IPv4.
	logic v4_ff; // Frame carries IPv4.
	logic frag_ff; // More-fragments or a fragment offset seen.
	logic [3:0] ihl_ff; // Header length in words.
	logic [15:0] tot_ff; // IPv4 total length.
	logic [15:0] ipf_ff; // Received header checksum field.
	logic [15:0] tpf_ff; // Received transport checksum field.
	logic [7:0] proto_ff; // Protocol number.
	logic [31:0] hsum_ff; // Header sum, field excluded.
	logic [31:0] tsum_ff; // Transport sum with addresses, field excluded.
	logic [TCO_IW-1:0] r; // Offset from the IPv4 header start.
	logic [TCO_IW-1:0] t; // Offset from the transport header start.
	logic [TCO_IW-1:0] ihl4; // Header length in bytes.
	logic [31:0] w; // Byte weighted by its position in a 16-bit word.
	logic in_hdr;
	logic in_tp;
	logic tp_fld;
	logic [15:0] tlen;
	logic [15:0] tp_raw;

	// Folds carries back into 16 bits.
	function automatic logic [15:0] tco_fold(input logic [31:0] x);
		logic [16:0] s;
		s = {1'b0, x[15:0]} + {1'b0, x[31:16]};
		s = {1'b0, s[15:0]} + {16'h0000, s[16]};
		return s[15:0];
	endfunction

	assign r = idx - base;
	assign ihl4 = {5'h00, ihl_ff, 2'b00};
	assign t = r - ihl4;
	// Even offsets are the high byte of a word, so an odd tail pads with zero.
	assign w = r[0] ? {24'h000000, data} : {16'h0000, data, 8'h00};
	assign in_hdr = (r == '0) ? (et_ok_ff && data[7:4] == TCO_IPV4_VER) : (v4_ff && r < ihl4);
	assign in_tp = v4_ff && r >= ihl4 && {5'h00, r} < tot_ff;
	assign tp_fld = (is_tcp && t[10:1] == TCO_TCP_CSUM[10:1])
		|| (is_udp && t[10:1] == TCO_UDP_CSUM[10:1]);

	// Captures the header fields that steer the sums.
	always_ff @(posedge sys_clk) begin
		if (srst || clr) begin
			et_hi_ff <= 1'b0;
			et_ok_ff <= 1'b0;
			v4_ff <= 1'b0;
			frag_ff <= 1'b0;
			ihl_ff <= '0;
			tot_ff <= '0;
			ipf_ff <= '0;
			tpf_ff <= '0;
			proto_ff <= '0;
		end else if (en) begin
			if (idx + TCO_ETYPE_HI_BACK == TCO_ETH_HDR) begin
				et_hi_ff <= data == TCO_ETYPE_HI;
			end
			if (idx + TCO_ETYPE_LO_BACK == TCO_ETH_HDR) begin
				et_ok_ff <= et_hi_ff && data == TCO_ETYPE_LO;
			end
			if (r == '0) begin
				v4_ff <= in_hdr;
				ihl_ff <= data[3:0];
			end
			if (v4_ff) begin
				case (r)
					TCO_IP_TOT_HI: tot_ff[15:8] <= data;
					TCO_IP_TOT_LO: tot_ff[7:0] <= data;
					TCO_IP_FRAG_HI: frag_ff <= data[TCO_MF_BIT] || data[4:0] != '0;
					TCO_IP_FRAG_LO: frag_ff <= frag_ff || data != '0;
					TCO_IP_PROTO: proto_ff <= data;
					TCO_IP_CSUM: ipf_ff[15:8] <= data;
					TCO_IP_CSUM + TCO_ETYPE_LO_BACK: ipf_ff[7:0] <= data;
					default: ;
				endcase
			end
			if (in_tp && tp_fld) begin
				tpf_ff <= t[0] ? {tpf_ff[15:8], data} : {data, tpf_ff[7:0]};
			end
		end
	end

	// Accumulates both sums; the pseudo-header addresses go into the transport sum too.
	always_ff @(posedge sys_clk) begin
		if (srst || clr) begin
			hsum_ff <= '0;
			tsum_ff <= '0;
		end else if (en) begin
			if (in_hdr && r[10:1] != TCO_IP_CSUM[10:1]) begin
				hsum_ff <= hsum_ff + w;
			end
			if ((v4_ff && r >= TCO_IP_ADDR_FIRST && r <= TCO_IP_ADDR_LAST) || (in_tp && !tp_fld)) begin
				tsum_ff <= tsum_ff + w;
			end
		end
	end

	assign is_v4 = v4_ff;
	assign is_tcp = proto_ff == TCO_PROTO_TCP;
	assign is_udp = proto_ff == TCO_PROTO_UDP;
	assign is_frag = frag_ff;
	assign ip_calc = ~tco_fold(hsum_ff);
	assign tlen = tot_ff - {5'h00, ihl4};
	// Protocol and transport length complete the pseudo-header.
	assign tp_raw = ~tco_fold(tsum_ff + {24'h000000, proto_ff} + {16'h0000, tlen});
	assign tp_calc = (is_udp && tp_raw == TCO_CSUM_ZERO) ? TCO_CSUM_ONES : tp_raw;
	assign ip_field = ipf_ff;
	assign tp_field = tpf_ff;
	assign ip_pos = base + TCO_IP_CSUM;
	assign tp_pos = base + ihl4 + (is_tcp ? TCO_TCP_CSUM : TCO_UDP_CSUM);
endmodule

// Top: transmit insertion path, receive check and format path, register port.
module tco_checksum_offload
	import tco_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [TCO_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic tx_in_valid,
	input wire logic [7:0] tx_in_data,
	input wire logic tx_in_last,
	input wire logic frame_offload_bypass,
	output logic tx_in_ready,
	output logic tx_out_valid,
	output logic [7:0] tx_out_data,
	output logic tx_out_last,
	input wire logic tx_out_ready,
	input wire logic rx_in_valid,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_last,
	input wire logic [31:0] rx_in_timestamp,
	input wire logic [7:0] rx_in_tag_dest,
	input wire logic [3:0] rx_in_port,
	input wire logic [4:0] rx_in_match_pair,
	input wire logic [13:0] rx_in_mac_flags,
	input wire logic v6_ext_header_error,
	input wire logic unlisted_next_header,
	input wire logic rx_in_v6_no_transport,
	output logic rx_in_ready,
	output logic rx_out_valid,
	output logic [31:0] rx_out_data,
	output logic rx_out_last,
	input wire logic rx_out_ready
);
	logic [TCO_CTRL_W-1:0] checksum_offload_control_ff; // Software control bits.
	logic [31:0] info0_ff; // Last information words sent.
	logic [31:0] info1_ff;
	logic [31:0] rdata_ff;
	logic [7:0] tx_mem [TCO_DEPTH]; // Transmit frame store.
	logic [7:0] rx_mem [TCO_DEPTH]; // Receive frame store.
	tco_tx_state_t tx_st_ff;
	tco_rx_state_t rx_st_ff;
	logic [TCO_IW-1:0] tx_cnt_ff, tx_len_ff, tx_j_ff, rx_cnt_ff, rx_olen_ff, rx_p_ff;
	logic tx_pad_ff, tx_byp_ff, tx_rdy_ff, tx_ov_ff, tx_ol_ff;
	logic [7:0] tx_od_ff;
	logic rx_pad_ff, rx_calc_ff, rx_tag_ff, rx_afe_ff, rx_rdy_ff, rx_ov_ff, rx_ol_ff;
	logic rx_v6e_ff, rx_unl_ff, rx_v6n_ff;
	logic [31:0] rx_od_ff, rx_acc_ff, rx_ts_ff;
	logic [7:0] rx_tdst_ff;
	logic [3:0] rx_port_ff;
	logic [4:0] rx_pair_ff;
	logic [13:0] rx_macf_ff;
	logic [12:0] rx_nw_ff; // Data words sent for this frame.
	// Parser results.
	logic tv4, ttcp, tudp, tfrag, rv4, rtcp, rudp, rfrag;
	logic [15:0] tipc, ttpc, ripc, rtpc, ripf, rtpf;
	logic [TCO_IW-1:0] tipp, ttpp, rtpp_unused, ripp_unused;
	logic tx_take, rx_take, tx_adv, rx_adv, tx_calc, tx_tp, tx_skip;
	logic rx_ipv4_header_sum_error, rx_tp_run, rx_tpng, rx_entry_ok, rx_emit;
	logic [7:0] tx_byte, rx_byte;
	logic [TCO_IW-1:0] rx_src, rx_fk;
	logic [47:0] rx_tag_word, rx_tag_sh;
	logic [31:0] nxt_word, nxt_info0, nxt_info1;

	assign tx_take = tx_in_valid && tx_rdy_ff;
	assign rx_take = rx_in_valid && rx_rdy_ff;
	assign tx_adv = !tx_ov_ff || tx_out_ready;
	assign rx_adv = !rx_ov_ff || rx_out_ready;

	tco_sum_unit u_tx_sum (.sys_clk(sys_clk), .srst(srst), .clr(tx_take && tx_cnt_ff == '0),
		.en(tx_take), .idx(tx_cnt_ff), .base(tx_pad_ff ? TCO_ETH_HDR + TCO_PAD_LEN : TCO_ETH_HDR),
		.data(tx_in_data), .is_v4(tv4), .is_tcp(ttcp), .is_udp(tudp), .is_frag(tfrag),
		.ip_calc(tipc), .tp_calc(ttpc), .ip_field(), .tp_field(), .ip_pos(tipp), .tp_pos(ttpp));
	tco_sum_unit u_rx_sum (.sys_clk(sys_clk), .srst(srst), .clr(rx_take && rx_cnt_ff == '0),
		.en(rx_take), .idx(rx_cnt_ff), .base(TCO_ETH_HDR), .data(rx_in_data), .is_v4(rv4),
		.is_tcp(rtcp), .is_udp(rudp), .is_frag(rfrag), .ip_calc(ripc), .tp_calc(rtpc),
		.ip_field(ripf), .tp_field(rtpf), .ip_pos(ripp_unused), .tp_pos(rtpp_unused));

	// Software control register and read port; reads answer one cycle later.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			checksum_offload_control_ff <= '0;
			rdata_ff <= '0;
		end else begin
			if (reg_wr && reg_addr == TCO_REG_CTRL) begin
				checksum_offload_control_ff <= reg_wdata[TCO_CTRL_W-1:0];
			end
			rdata_ff <= '0;
			if (reg_rd) begin
				case (reg_addr)
					TCO_REG_CTRL: rdata_ff <= {27'h0000000, checksum_offload_control_ff};
					TCO_REG_INFO0: rdata_ff <= info0_ff;
					TCO_REG_INFO1: rdata_ff <= info1_ff;
					TCO_REG_STAT: begin
						rdata_ff[TCO_STAT_TXBUSY] <= tx_st_ff != TCO_TX_FILL;
						rdata_ff[TCO_STAT_RXBUSY] <= rx_st_ff != TCO_RX_FILL;
					end
					default: rdata_ff <= '0;
				endcase
			end
		end
	end

	// Transmit byte chooser: sums are patched over their fields as the frame leaves.
	assign tx_calc = tx_pad_ff && !tx_byp_ff && tv4;
	assign tx_tp = tx_calc && (ttcp || tudp) && !tfrag;
	assign tx_skip = tx_pad_ff && tx_j_ff >= TCO_ETH_HDR && tx_j_ff < TCO_ETH_HDR + TCO_PAD_LEN;
	always_comb begin
		tx_byte = tx_mem[tx_j_ff];
		if (tx_calc && tx_j_ff == tipp) begin
			tx_byte = tipc[15:8];
		end else if (tx_calc && tx_j_ff == tipp + TCO_ETYPE_LO_BACK) begin
			tx_byte = tipc[7:0];
		end else if (tx_tp && tx_j_ff == ttpp) begin
			tx_byte = ttpc[15:8];
		end else if (tx_tp && tx_j_ff == ttpp + TCO_ETYPE_LO_BACK) begin
			tx_byte = ttpc[7:0];
		end
	end

	// Transmit frame store writes.
	always_ff @(posedge sys_clk) begin
		if (tx_take && tx_cnt_ff < TCO_MAX_LEN) begin
			tx_mem[tx_cnt_ff] <= tx_in_data;
		end
	end

	// Transmit sequencer: fill the store, then send with padding dropped.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_st_ff <= TCO_TX_FILL;
			tx_rdy_ff <= 1'b1;
			tx_cnt_ff <= '0;
			tx_len_ff <= '0;
			tx_j_ff <= '0;
			tx_pad_ff <= 1'b0;
			tx_byp_ff <= 1'b0;
			tx_ov_ff <= 1'b0;
			tx_ol_ff <= 1'b0;
			tx_od_ff <= '0;
		end else begin
			if (tx_adv) begin
				tx_ov_ff <= 1'b0;
			end
			unique case (tx_st_ff)
				TCO_TX_FILL: begin
					if (tx_take) begin
						if (tx_cnt_ff == '0) begin
							// The supplier pads the header whenever offload is on.
							tx_pad_ff <= checksum_offload_control_ff[TCO_CTRL_TXEN];
							tx_byp_ff <= frame_offload_bypass;
						end
						if (tx_cnt_ff < TCO_MAX_LEN) begin
							tx_cnt_ff <= tx_cnt_ff + TCO_ETYPE_LO_BACK;
						end
						if (tx_in_last) begin
							tx_len_ff <= tx_cnt_ff;
							tx_j_ff <= '0;
							tx_rdy_ff <= 1'b0;
							tx_st_ff <= TCO_TX_SEND;
						end
					end
				end
				TCO_TX_SEND: begin
					if (tx_adv) begin
						if (!tx_skip) begin
							tx_ov_ff <= 1'b1;
							tx_od_ff <= tx_byte;
							tx_ol_ff <= tx_j_ff == tx_len_ff;
						end
						tx_j_ff <= tx_j_ff + TCO_ETYPE_LO_BACK;
						if (tx_j_ff == tx_len_ff) begin
							tx_cnt_ff <= '0;
							tx_rdy_ff <= 1'b1;
							tx_st_ff <= TCO_TX_FILL;
						end
					end
				end
			endcase
		end
	end

	// Receive verdicts, stable once the frame is stored.
	assign rx_ipv4_header_sum_error = rx_calc_ff && rv4 && ripc != ripf;
	assign rx_tp_run = rx_calc_ff && rv4 && (rtcp || rudp) && !rfrag && !rx_ipv4_header_sum_error
		&& !rx_v6e_ff && !rx_unl_ff && !rx_v6n_ff;
	assign rx_tpng = rx_tp_run && !(rudp && rtpf == TCO_CSUM_ZERO) && rtpc != rtpf;
	assign rx_entry_ok = !rx_afe_ff && rx_pair_ff != '0;
	assign rx_tag_word = {rx_ts_ff, rx_tdst_ff, rx_port_ff, 4'(rx_pair_ff - 5'h01)};
	assign rx_tag_sh = rx_tag_word << {rx_p_ff[2:0], 3'b000};
	assign rx_src = (rx_pad_ff && rx_p_ff >= TCO_ETH_HDR + TCO_PAD_LEN) ? rx_p_ff - TCO_PAD_LEN
		: rx_p_ff;
	assign rx_fk = rx_p_ff - (rx_olen_ff - TCO_FCS_LEN);

	// Receive byte chooser: pad, tag and FCS replacement over the stored frame.
	always_comb begin
		rx_byte = rx_mem[rx_src];
		if (rx_pad_ff && rx_p_ff >= TCO_ETH_HDR && rx_p_ff < TCO_ETH_HDR + TCO_PAD_LEN) begin
			rx_byte = '0;
		end else if (rx_tag_ff && rx_p_ff < TCO_DA_LEN) begin
			rx_byte = rx_tag_sh[47:40];
		end else if (rx_tp_run && rx_p_ff >= rx_olen_ff - TCO_FCS_LEN) begin
			rx_byte = (rx_fk == '0) ? rtpc[15:8] : (rx_fk == TCO_ETYPE_LO_BACK) ? rtpc[7:0] : '0;
		end
		nxt_word = rx_acc_ff;
		nxt_word[{rx_p_ff[1:0], 3'b000} +: 8] = rx_byte;
	end
	assign rx_emit = rx_p_ff[1:0] == 2'b11 || rx_p_ff + TCO_ETYPE_LO_BACK == rx_olen_ff;
	// Length as word count over last-word code, so the byte count is that minus three.
	assign nxt_info0 = {3'b000, rx_nw_ff, 2'(rx_olen_ff - TCO_ETYPE_LO_BACK), rx_macf_ff};
	always_comb begin
		nxt_info1 = '0;
		nxt_info1[TCO_I1_ENTRY_OK] = rx_tag_ff && rx_entry_ok;
		nxt_info1[TCO_I1_IPV4_HEADER_SUM_ERROR] = rx_ipv4_header_sum_error;
		nxt_info1[TCO_I1_TPNG] = rx_tpng;
		nxt_info1[TCO_I1_V6ERR] = rx_pad_ff && rx_v6e_ff;
		nxt_info1[TCO_I1_UNLIST] = rx_pad_ff && rx_unl_ff;
		nxt_info1[TCO_I1_TYPEIP] = rx_pad_ff && rv4;
	end

	// Receive frame store writes.
	always_ff @(posedge sys_clk) begin
		if (rx_take && rx_cnt_ff < TCO_MAX_LEN) begin
			rx_mem[rx_cnt_ff] <= rx_in_data;
		end
	end

	// Receive sequencer: fill, send data words, align, then the two information words.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_st_ff <= TCO_RX_FILL;
			rx_rdy_ff <= 1'b1;
			{rx_cnt_ff, rx_olen_ff, rx_p_ff, rx_nw_ff} <= '0;
			{rx_pad_ff, rx_calc_ff, rx_tag_ff, rx_afe_ff} <= '0;
			{rx_v6e_ff, rx_unl_ff, rx_v6n_ff, rx_ov_ff, rx_ol_ff} <= '0;
			{rx_od_ff, rx_acc_ff, rx_ts_ff, info0_ff, info1_ff} <= '0;
			{rx_tdst_ff, rx_port_ff, rx_pair_ff, rx_macf_ff} <= '0;
		end else begin
			if (rx_adv) begin
				rx_ov_ff <= 1'b0;
			end
			unique case (rx_st_ff)
				TCO_RX_FILL: begin
					if (rx_take) begin
						if (rx_cnt_ff == '0) begin
							rx_pad_ff <= checksum_offload_control_ff[TCO_CTRL_RXEN];
							rx_calc_ff <= checksum_offload_control_ff[TCO_CTRL_RXEN]
								&& !checksum_offload_control_ff[TCO_CTRL_SUPP];
							rx_tag_ff <= checksum_offload_control_ff[TCO_CTRL_TAG];
							rx_afe_ff <= checksum_offload_control_ff[TCO_CTRL_AFE];
							rx_ts_ff <= rx_in_timestamp;
							rx_tdst_ff <= rx_in_tag_dest;
							rx_port_ff <= rx_in_port;
							rx_pair_ff <= rx_in_match_pair;
						end
						if (rx_cnt_ff < TCO_MAX_LEN) begin
							rx_cnt_ff <= rx_cnt_ff + TCO_ETYPE_LO_BACK;
						end
						if (rx_in_last) begin
							rx_olen_ff <= rx_cnt_ff + TCO_ETYPE_LO_BACK
								+ (rx_pad_ff ? TCO_PAD_LEN : '0);
							rx_macf_ff <= rx_in_mac_flags;
							rx_v6e_ff <= v6_ext_header_error;
							rx_unl_ff <= unlisted_next_header;
							rx_v6n_ff <= rx_in_v6_no_transport;
							{rx_p_ff, rx_nw_ff, rx_acc_ff} <= '0;
							rx_rdy_ff <= 1'b0;
							rx_st_ff <= TCO_RX_DATA;
						end
					end
				end
				TCO_RX_DATA: begin
					if (rx_adv) begin
						rx_acc_ff <= rx_emit ? '0 : nxt_word;
						rx_ov_ff <= rx_emit;
						rx_od_ff <= nxt_word;
						rx_ol_ff <= 1'b0;
						rx_nw_ff <= rx_nw_ff + {12'h000, rx_emit};
						rx_p_ff <= rx_p_ff + TCO_ETYPE_LO_BACK;
						if (rx_p_ff + TCO_ETYPE_LO_BACK == rx_olen_ff) begin
							rx_st_ff <= TCO_RX_ALIGN;
						end
					end
				end
				TCO_RX_ALIGN: begin
					if (rx_adv) begin
						// An odd word count needs one zero word to reach a 64-bit boundary.
						rx_ov_ff <= rx_nw_ff[0];
						rx_od_ff <= '0;
						rx_st_ff <= TCO_RX_INFO0;
					end
				end
				TCO_RX_INFO0: begin
					if (rx_adv) begin
						rx_ov_ff <= 1'b1;
						rx_od_ff <= nxt_info0;
						info0_ff <= nxt_info0;
						rx_st_ff <= TCO_RX_INFO1;
					end
				end
				TCO_RX_INFO1: begin
					if (rx_adv) begin
						rx_ov_ff <= 1'b1;
						rx_od_ff <= nxt_info1;
						rx_ol_ff <= 1'b1;
						info1_ff <= nxt_info1;
						rx_cnt_ff <= '0;
						rx_rdy_ff <= 1'b1;
						rx_st_ff <= TCO_RX_FILL;
					end
				end
				default: rx_st_ff <= TCO_RX_FILL;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;
	assign tx_in_ready = tx_rdy_ff;
	assign tx_out_valid = tx_ov_ff;
	assign tx_out_data = tx_od_ff;
	assign tx_out_last = tx_ol_ff;
	assign rx_in_ready = rx_rdy_ff;
	assign rx_out_valid = rx_ov_ff;
	assign rx_out_data = rx_od_ff;
	assign rx_out_last = rx_ol_ff;
endmodule

`default_nettype wire

// ===== tco_checksum_offload_tb.sv
// Testbench for the checksum offload block.
// Assumes the far-side model collects output units in its queues.
`timescale 1ns/1ns
`default_nettype none
module tco_checksum_offload_tb;
	import tco_pkg::*;
	logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
	logic [7:0] reg_addr = 8'h0, tx_in_data = 8'h0, rx_in_data = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rx_out_data, rx_in_timestamp = 32'h0;
	logic tx_in_valid = 1'b0, tx_in_last = 1'b0, frame_offload_bypass = 1'b0;
	logic rx_in_valid = 1'b0, rx_in_last = 1'b0, rx_in_v6_no_transport = 1'b0;
	logic v6_ext_header_error = 1'b1, unlisted_next_header = 1'b1;
	logic [13:0] rx_in_mac_flags = 14'h2a5b;
	logic [7:0] rx_in_tag_dest = 8'h0, tx_out_data;
	logic [3:0] rx_in_port = 4'h0;
	logic [4:0] rx_in_match_pair = 5'h0;
	logic tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready;
	logic rx_in_ready, rx_out_valid, rx_out_last, rx_out_ready;
	logic [7:0] fr[36]; // Padded IPv4 frame, protocol 1, total length 20.
	int n_mismatch = 0, total_checks = 0;
	tco_checksum_offload u_tco_checksum_offload (.*);
	tco_mac_model u_mac (.*);
	initial forever #2 sys_clk = ~sys_clk;
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data are taken in the single cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge sys_clk);
	endtask
	// Header sum over the IPv4 bytes with the sum field still zero.
	function automatic logic [15:0] ip_sum();
		logic [31:0] s;
		s = 32'h0;
		for (int i = 16; i < 36; i += 2) s += {fr[i], fr[i+1]};
		s = s[15:0] + s[31:16];
		s = s[15:0] + s[31:16];
		return ~s[15:0];
	endfunction
	task automatic t_regs();
		logic [31:0] d;
		rd(TCO_REG_CTRL, d);
		chk(d, 32'h0);
		wr(TCO_REG_CTRL, 32'h1f);
		rd(TCO_REG_CTRL, d);
		chk(d, 32'h1f);
		rd(8'h10, d);
		chk(d, 32'h0);
	endtask
	// Sends the frame and checks the line bytes: pad skipped, sum inserted.
	task automatic t_tx(input logic [31:0] c, input logic b, input int sk, input logic [15:0] cs);
		int k;
		int j;
		wr(TCO_REG_CTRL, c);
		u_mac.tx_q.delete();
		frame_offload_bypass <= b;
		for (int i = 0; i < 36; i++) begin
			tx_in_valid <= 1'b1;
			tx_in_data <= fr[i];
			tx_in_last <= (i == 35);
			do @(posedge sys_clk); while (tx_in_ready !== 1'b1);
		end
		tx_in_valid <= 1'b0;
		for (k = 0; k < 400 && u_mac.tx_q.size() < 36 - sk; k++) @(posedge sys_clk);
		chk(u_mac.tx_q.size(), 36 - sk);
		for (int i = 0; i < 36 - sk; i++) begin
			j = (i >= 14) ? i + sk : i;
			chk(u_mac.tx_q[i], j == 26 ? cs[15:8] : j == 27 ? cs[7:0] : fr[j]);
		end
	endtask
	// Receive of nine bytes: order, odd-count zero word, length code e, flags f.
	task automatic t_rx_raw(input logic [31:0] c, input logic [1:0] e, input logic [5:0] f);
		logic [31:0] d;
		int k;
		wr(TCO_REG_CTRL, c);
		u_mac.rx_q.delete();
		for (int i = 0; i < 9; i++) begin
			rx_in_valid <= 1'b1;
			rx_in_data <= fr[i];
			rx_in_last <= (i == 8);
			do @(posedge sys_clk); while (rx_in_ready !== 1'b1);
		end
		rx_in_valid <= 1'b0;
		for (k = 0; k < 400 && u_mac.rx_q.size() < 6; k++) @(posedge sys_clk);
		chk(u_mac.rx_q.size(), 6);
		chk(u_mac.rx_q[0], {fr[3], fr[2], fr[1], fr[0]});
		chk(u_mac.rx_q[2][7:0], fr[8]);
		chk(u_mac.rx_q[3], 32'h0);
		chk(u_mac.rx_q[4], {3'h0, 13'h3, e, 14'h2a5b});
		chk(u_mac.rx_q[5][8:3], f);
		rd(TCO_REG_INFO0, d);
		chk(d, {3'h0, 13'h3, e, 14'h2a5b});
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Main sequence; the supplier pads the header and sets a true length.
	initial begin
		for (int i = 0; i < 36; i++) fr[i] = (i < 12 || i >= 28) ? 8'(i + 1) : 8'h0;
		fr[12] = 8'h08;
		fr[16] = 8'h45;
		fr[19] = 8'h14;
		fr[24] = 8'h40;
		fr[25] = 8'h01;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs();
		t_tx(32'h1, 1'b0, 2, ip_sum());
		slow <= 1'b1;
		t_tx(32'h1, 1'b1, 2, 16'h0);
		t_tx(32'h0, 1'b1, 0, 16'h0);
		t_rx_raw(32'h0, 2'h0, 6'h00);
		t_rx_raw(32'h2, 2'h2, 6'h06);
		t_rx_raw(32'h6, 2'h2, 6'h06);
		end_of_test();
	end
	// Watchdog: the run needs a few hundred cycles.
	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== tco_chk.sv
// Port checker for the checksum offload block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module tco_chk
	import tco_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [TCO_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic tx_in_valid,
	input wire logic tx_in_last,
	input wire logic tx_in_ready,
	input wire logic tx_out_valid,
	input wire logic [7:0] tx_out_data,
	input wire logic tx_out_last,
	input wire logic tx_out_ready,
	input wire logic rx_in_valid,
	input wire logic rx_in_last,
	input wire logic rx_in_ready,
	input wire logic rx_out_valid,
	input wire logic rx_out_last,
	input wire logic rx_out_ready
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside the answer cycle");
	a_ctrl_read_back: assert property (reg_wr && reg_addr == TCO_REG_CTRL ##1
		reg_rd && reg_addr == TCO_REG_CTRL |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
		else $error("control read back differs from write");
	a_unmapped_read: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_tx_out_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid
		&& $stable(tx_out_data) && $stable(tx_out_last))
		else $error("transmit byte changed before acceptance");
	a_tx_send_start: assert property (tx_in_valid && tx_in_ready && tx_in_last |=>
		!tx_in_ready ##1 tx_out_valid)
		else $error("transmit send did not start after last byte");
	a_rx_refuse_input: assert property (rx_in_valid && rx_in_ready && rx_in_last |=>
		!rx_in_ready [*4])
		else $error("receive input taken while formatting");
	a_rx_record_end: assert property (rx_out_valid && rx_out_ready && rx_out_last |=>
		!rx_out_valid)
		else $error("word emitted right after the information record");
	a_reset_ready: assert property ($fell(srst) |-> tx_in_ready && rx_in_ready)
		else $error("inputs not ready after reset");
	a_tx_last_ready: assert property ($rose(tx_out_last) |-> tx_out_valid && tx_in_ready
		&& !$past(tx_in_ready))
		else $error("last byte shown without input ready returning");
endmodule
bind tco_checksum_offload tco_chk u_chk (.*);
`default_nettype wire

// ===== tco_mac_model.sv
// Far-side model: MAC transmit sink and buffer DMA receive sink.
// Assumes the same clock; the slow input makes it stall on a fixed pattern.
`timescale 1ns/1ns
`default_nettype none
module tco_mac_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic slow,
	input wire logic tx_out_valid,
	input wire logic [7:0] tx_out_data,
	output logic tx_out_ready,
	input wire logic rx_out_valid,
	input wire logic [31:0] rx_out_data,
	output logic rx_out_ready
);
	logic [7:0] tx_q[$]; // Bytes taken from the transmit stream.
	logic [31:0] rx_q[$]; // Words taken from the receive stream.
	logic [1:0] cnt_ff; // Stall pattern counter.
	// The counter steps after each edge, so ready changes only there.
	always_ff @(posedge sys_clk) begin
		cnt_ff <= srst ? 2'h0 : cnt_ff + 2'h1;
	end
	assign tx_out_ready = !slow || cnt_ff[0];
	assign rx_out_ready = !slow || cnt_ff[1];
	// Units are collected at the edge that accepts them.
	always @(posedge sys_clk) begin
		if (!srst && tx_out_valid && tx_out_ready) tx_q.push_back(tx_out_data);
		if (!srst && rx_out_valid && rx_out_ready) rx_q.push_back(rx_out_data);
	end
endmodule
`default_nettype wire

// ===== tco_pkg.sv
// Shared constants for the checksum offload block: register map, frame offsets, states.
// Assumes a byte-wide frame datapath and a plain single-cycle register port.
package tco_pkg;
	// Register port and map.
	localparam int TCO_AW = 8;
	localparam logic [7:0] TCO_REG_CTRL = 8'h00;
	localparam logic [7:0] TCO_REG_INFO0 = 8'h04;
	localparam logic [7:0] TCO_REG_INFO1 = 8'h08;
	localparam logic [7:0] TCO_REG_STAT = 8'h0c;
	// Control bits.
	localparam int TCO_CTRL_W = 5;
	localparam int TCO_CTRL_TXEN = 0;
	localparam int TCO_CTRL_RXEN = 1;
	localparam int TCO_CTRL_SUPP = 2;
	localparam int TCO_CTRL_TAG = 3;
	localparam int TCO_CTRL_AFE = 4;
	// Status bits.
	localparam int TCO_STAT_TXBUSY = 0;
	localparam int TCO_STAT_RXBUSY = 1;
	// Second information word flag positions.
	localparam int TCO_I1_ENTRY_OK = 8;
	localparam int TCO_I1_IPV4_HEADER_SUM_ERROR = 7;
	localparam int TCO_I1_TPNG = 6;
	localparam int TCO_I1_V6ERR = 5;
	localparam int TCO_I1_UNLIST = 4;
	localparam int TCO_I1_TYPEIP = 3;
	// Frame buffers.
	localparam int TCO_IW = 11;
	localparam int TCO_DEPTH = 2048;
	localparam logic [10:0] TCO_MAX_LEN = 11'h7fb;
	// Frame layout, byte offsets.
	localparam logic [10:0] TCO_ETH_HDR = 11'h00e;
	localparam logic [10:0] TCO_PAD_LEN = 11'h002;
	localparam logic [10:0] TCO_DA_LEN = 11'h006;
	localparam logic [10:0] TCO_FCS_LEN = 11'h004;
	localparam logic [10:0] TCO_ETYPE_HI_BACK = 11'h002;
	localparam logic [10:0] TCO_ETYPE_LO_BACK = 11'h001;
	localparam logic [10:0] TCO_IP_TOT_HI = 11'h002;
	localparam logic [10:0] TCO_IP_TOT_LO = 11'h003;
	localparam logic [10:0] TCO_IP_FRAG_HI = 11'h006;
	localparam logic [10:0] TCO_IP_FRAG_LO = 11'h007;
	localparam logic [10:0] TCO_IP_PROTO = 11'h009;
	localparam logic [10:0] TCO_IP_CSUM = 11'h00a;
	localparam logic [10:0] TCO_IP_ADDR_FIRST = 11'h00c;
	localparam logic [10:0] TCO_IP_ADDR_LAST = 11'h013;
	localparam logic [10:0] TCO_TCP_CSUM = 11'h010;
	localparam logic [10:0] TCO_UDP_CSUM = 11'h006;
	localparam int TCO_MF_BIT = 5;
	// Field codes.
	localparam logic [7:0] TCO_ETYPE_HI = 8'h08;
	localparam logic [7:0] TCO_ETYPE_LO = 8'h00;
	localparam logic [3:0] TCO_IPV4_VER = 4'h4;
	localparam logic [7:0] TCO_PROTO_TCP = 8'h06;
	localparam logic [7:0] TCO_PROTO_UDP = 8'h11;
	localparam logic [15:0] TCO_CSUM_ZERO = 16'h0000;
	localparam logic [15:0] TCO_CSUM_ONES = 16'hffff;
	// States.
	typedef enum logic {TCO_TX_FILL, TCO_TX_SEND} tco_tx_state_t;
	typedef enum logic [2:0] {TCO_RX_FILL, TCO_RX_DATA, TCO_RX_ALIGN, TCO_RX_INFO0,
		TCO_RX_INFO1} tco_rx_state_t;
endpackage
